// *** rtl/periodic_wakeup_params.svh ***
`ifndef PERIODIC_WAKEUP_PARAMS_SVH
`define PERIODIC_WAKEUP_PARAMS_SVH
// register byte offsets; status, mask and period follow the control byte
`define CTRL_OFFSET 16'h02f2
`define IRQ_STATUS_OFFSET 16'h0300
`define IRQ_MASK_OFFSET 16'h0304
`define PERIOD_OFFSET 16'h0308
// control field positions
`define CLK_SEL_BIT 7
`define EXT_SEL_BIT 4
`define EXT_EN_BIT 3
`define FEAT_EN_BIT 2
`define IRQ_EN_BIT 1
`define FLAG_BIT 0
// reset values
`define CTRL_RESET 8'h00
`define MASK_RESET 8'h00
`define PERIOD_RESET 16'h0009
// width of the external pulse in counting-clock ticks, equal to the min period
`define PULSE_TICKS 16'h0001
`endif

// *** rtl/periodic_wakeup_pkg.sv ***
package periodic_wakeup_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN = 2'b10
  } timer_state_t;
endpackage

// *** rtl/autonomous_periodic_interrupt.sv ***
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/1ns
`include "periodic_wakeup_params.svh"
// Functional notes
// - clock select: 0 internal rc, 1 bus
// - clock select writable only when feature disabled
// - clock waveform has twice the period
// - pulse mode: short high pulse each period
// - pin driven only with external enable and feature
// - feature enable starts timer, clear stops it
// - interrupt request while enabled and flag set
// - flag set on each elapsed period
// - flag cleared only by writing one
// - clear beats set in same cycle
// - rc clock absent during regulator shutdown
module autonomous_periodic_interrupt
  import periodic_wakeup_pkg::*;
#(
  parameter int PERIOD_W = 16
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // avalon-mm slave
  input wire logic [15:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic [1:0] response,
  // internal rc oscillator tick, asynchronous level toggle
  input wire logic rcTick,
  // regulator enable, low means shutdown
  input wire logic regulator_enable_input,
  // interrupt request and external pin
  output logic periodicIrq,
  output logic extPinOut,
  output logic extPinOe,
  output logic irq
);

  logic [7:0] ctrl_reg;
  logic [7:0] irqStatus_reg;
  logic [7:0] irqMask_reg;
  logic [PERIOD_W-1:0] period_reg;
  logic [PERIOD_W-1:0] count_reg;
  logic [PERIOD_W-1:0] pulse_reg;
  logic wave_reg;
  logic pinOut_reg;
  logic pinOe_reg;
  logic [31:0] readdata_reg;
  logic ack_reg;
  logic [2:0] rcSync_reg;
  logic [1:0] enSync_reg;
  timer_state_t state_reg;
  logic rcEdge;
  logic tick;
  logic timeout;
  logic wrCtrl;
  logic clearFlag;
  logic access;
  logic wrCommit;
  logic featEn;
  logic [7:0] ctrlRead;

  assign featEn = ctrl_reg[`FEAT_EN_BIT];
  assign access = (read | write) & ~ack_reg;
  // writes land at the edge where waitrequest is seen low, not before
  assign wrCommit = write & ack_reg;
  assign wrCtrl = wrCommit & (address == `CTRL_OFFSET) & byteenable[0];
  assign clearFlag = wrCtrl & writedata[`FLAG_BIT];

  // three flip-flops on the rc input and two on the enable, rc edge taken between the second and third
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rcSync_reg <= 3'h0;
      enSync_reg <= 2'h0;
    end else begin
      rcSync_reg <= {rcSync_reg[1:0], rcTick};
      enSync_reg <= {enSync_reg[0], regulator_enable_input};
    end
  end
  assign rcEdge = rcSync_reg[2] ^ rcSync_reg[1];

  // rc source is dead in shutdown; bus source counts every cycle
  assign tick = ctrl_reg[`CLK_SEL_BIT] ? 1'b1 :
                (rcEdge & enSync_reg[1]);
  assign timeout = (state_reg == ST_RUN) & tick & (count_reg == '0);

  // control register; flag bit kept here
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ctrl_reg <= `CTRL_RESET;
    end else begin
      if (wrCtrl) begin
        ctrl_reg[6:1] <= {2'h0, writedata[4:1]};
        // a write that also sets the enable leaves the source alone
        if (!featEn && !writedata[`FEAT_EN_BIT]) begin
          ctrl_reg[`CLK_SEL_BIT] <= writedata[`CLK_SEL_BIT];
        end
      end
      // clear has precedence over set for this flag
      if (clearFlag) begin
        ctrl_reg[`FLAG_BIT] <= 1'b0;
      end else if (timeout) begin
        ctrl_reg[`FLAG_BIT] <= 1'b1;
      end
    end
  end

  // timer state: enable starts from full period, disable stops
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_reg <= ST_IDLE;
      count_reg <= '0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          count_reg <= period_reg;
          if (featEn) begin
            state_reg <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (!featEn) begin
            state_reg <= ST_IDLE;
          end else if (timeout) begin
            count_reg <= period_reg;
          end else if (tick) begin
            count_reg <= count_reg - 1'b1;
          end
        end
      endcase
    end
  end

  // waveform generation: toggle clock or short pulse per period
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wave_reg <= 1'b0;
      pulse_reg <= '0;
    end else if (state_reg != ST_RUN) begin
      wave_reg <= 1'b0;
      pulse_reg <= '0;
    end else begin
      if (timeout) begin
        wave_reg <= ~wave_reg;
        pulse_reg <= PERIOD_W'(`PULSE_TICKS);
      end else if (tick && pulse_reg != '0) begin
        pulse_reg <= pulse_reg - 1'b1;
      end
    end
  end

  // pin drive, gated by external enable bit and feature enable
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pinOut_reg <= 1'b0;
      pinOe_reg <= 1'b0;
    end else begin
      pinOe_reg <= ctrl_reg[`EXT_EN_BIT] & featEn;
      pinOut_reg <= (ctrl_reg[`EXT_EN_BIT] & featEn) &
        (ctrl_reg[`EXT_SEL_BIT] ? wave_reg : (pulse_reg != '0));
    end
  end
  assign extPinOut = pinOut_reg;
  assign extPinOe = pinOe_reg;

  // periodic request follows the flag while enabled
  assign periodicIrq = ctrl_reg[`IRQ_EN_BIT] & ctrl_reg[`FLAG_BIT];

  // sticky event status, write one to clear, set wins
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      irqStatus_reg <= 8'h00;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (i == 0 && timeout) begin
          irqStatus_reg[i] <= 1'b1;
        end else if (wrCommit && address == `IRQ_STATUS_OFFSET &&
                     byteenable[0] && writedata[i]) begin
          irqStatus_reg[i] <= 1'b0;
        end
      end
      irqStatus_reg[7:1] <= 7'h00;
    end
  end

  // mask and period registers
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      irqMask_reg <= `MASK_RESET;
      period_reg <= PERIOD_W'(`PERIOD_RESET);
    end else if (wrCommit) begin
      if (address == `IRQ_MASK_OFFSET && byteenable[0]) begin
        irqMask_reg <= {7'h00, writedata[0]};
      end
      if (address == `PERIOD_OFFSET && byteenable[0]) begin
        period_reg[7:0] <= writedata[7:0];
      end
      if (address == `PERIOD_OFFSET && byteenable[1]) begin
        period_reg[PERIOD_W-1:8] <= writedata[PERIOD_W-1:8];
      end
    end
  end
  assign irq = |(irqStatus_reg & irqMask_reg);

  // read mux: control reads bits 7,4..0, others zero
  assign ctrlRead = {ctrl_reg[7], 2'h0, ctrl_reg[4:0]};
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      readdata_reg <= 32'h0000_0000;
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= access;
      if (read && access) begin
        unique case (address)
          `CTRL_OFFSET: readdata_reg <= {24'h0, ctrlRead};
          `IRQ_STATUS_OFFSET: readdata_reg <= {24'h0, irqStatus_reg};
          `IRQ_MASK_OFFSET: readdata_reg <= {24'h0, irqMask_reg};
          `PERIOD_OFFSET: readdata_reg <= 32'(period_reg);
          default: readdata_reg <= 32'h0000_0000;
        endcase
      end
    end
  end
  assign readdata = readdata_reg;
  assign waitrequest = (read | write) & ~ack_reg;
  assign response = 2'h0;

  // flag behaviour: clear wins, set on timeout, held otherwise
  a_flag_clear_wins: assert property (
    @(posedge ref_clk) disable iff (srst)
    clearFlag |=> !ctrl_reg[`FLAG_BIT])
    else $error("flag not cleared");
  a_flag_set: assert property (
    @(posedge ref_clk) disable iff (srst)
    timeout && !clearFlag |=> ctrl_reg[`FLAG_BIT])
    else $error("flag not set on timeout");
  a_flag_hold: assert property (
    @(posedge ref_clk) disable iff (srst)
    ctrl_reg[`FLAG_BIT] && !clearFlag |=> ctrl_reg[`FLAG_BIT])
    else $error("flag dropped without clear");
  a_status_set: assert property (
    @(posedge ref_clk) disable iff (srst)
    timeout |=> irqStatus_reg[0])
    else $error("status not set on timeout");

  // clock select write protection and periodic request
  a_clksel_locked: assert property (
    @(posedge ref_clk) disable iff (srst)
    featEn |=> $stable(ctrl_reg[`CLK_SEL_BIT]))
    else $error("clock select changed while enabled");
  a_clksel_same_write: assert property (
    @(posedge ref_clk) disable iff (srst)
    wrCtrl && writedata[`FEAT_EN_BIT] |=> $stable(ctrl_reg[`CLK_SEL_BIT]))
    else $error("clock select changed by enabling write");
  a_clksel_free: assert property (
    @(posedge ref_clk) disable iff (srst)
    wrCtrl && !featEn && !writedata[`FEAT_EN_BIT] |=>
      ctrl_reg[`CLK_SEL_BIT] == $past(writedata[`CLK_SEL_BIT]))
    else $error("clock select not written while disabled");
  a_irq_request: assert property (
    @(posedge ref_clk) disable iff (srst)
    periodicIrq == (ctrl_reg[`IRQ_EN_BIT] && ctrl_reg[`FLAG_BIT]))
    else $error("request mismatch");

  // pin gating and waveform routing
  a_pin_gated: assert property (
    @(posedge ref_clk) disable iff (srst)
    !(ctrl_reg[`EXT_EN_BIT] && featEn) |=> !extPinOe && !extPinOut)
    else $error("pin driven while gated");
  a_pin_oe_on: assert property (
    @(posedge ref_clk) disable iff (srst)
    ctrl_reg[`EXT_EN_BIT] && featEn |=> extPinOe)
    else $error("pin not driven while routed");
  a_pin_clock: assert property (
    @(posedge ref_clk) disable iff (srst)
    ctrl_reg[`EXT_EN_BIT] && featEn && ctrl_reg[`EXT_SEL_BIT] |=>
      extPinOut == $past(wave_reg))
    else $error("pin does not carry clock wave");
  a_pin_pulse: assert property (
    @(posedge ref_clk) disable iff (srst)
    ctrl_reg[`EXT_EN_BIT] && featEn && !ctrl_reg[`EXT_SEL_BIT] |=>
      extPinOut == ($past(pulse_reg) != '0))
    else $error("pin does not carry pulse");

  // timer source and sequencing
  a_no_tick_shut: assert property (
    @(posedge ref_clk) disable iff (srst)
    !ctrl_reg[`CLK_SEL_BIT] && !enSync_reg[1] |-> !timeout)
    else $error("rc timeout in shutdown");
  a_shut_count_hold: assert property (
    @(posedge ref_clk) disable iff (srst)
    state_reg == ST_RUN && !ctrl_reg[`CLK_SEL_BIT] && !enSync_reg[1] |=>
      $stable(count_reg))
    else $error("count moved in shutdown");
  a_timer_reload: assert property (
    @(posedge ref_clk) disable iff (srst)
    timeout && featEn |=> count_reg == $past(period_reg))
    else $error("no reload after timeout");
  a_count_step: assert property (
    @(posedge ref_clk) disable iff (srst)
    state_reg == ST_RUN && featEn && tick && !timeout |=>
      count_reg == $past(count_reg) - 1'b1)
    else $error("count did not step");
  a_timer_stop: assert property (
    @(posedge ref_clk) disable iff (srst)
    !featEn |=> state_reg == ST_IDLE)
    else $error("timer runs while disabled");
  a_run_on_enable: assert property (
    @(posedge ref_clk) disable iff (srst)
    featEn && state_reg == ST_IDLE |=> state_reg == ST_RUN)
    else $error("timer not started by enable");
  a_wave_idle: assert property (
    @(posedge ref_clk) disable iff (srst)
    state_reg == ST_IDLE |=> !wave_reg)
    else $error("wave active while stopped");
  a_wave_toggle: assert property (
    @(posedge ref_clk) disable iff (srst)
    timeout && featEn |=> wave_reg != $past(wave_reg))
    else $error("clock wave not toggled");
  a_pulse_start: assert property (
    @(posedge ref_clk) disable iff (srst)
    timeout && featEn |=> pulse_reg != '0)
    else $error("pulse not started");
  a_bus_bus_clk: assert property (
    @(posedge ref_clk) disable iff (srst)
    ctrl_reg[`CLK_SEL_BIT] |-> tick)
    else $error("bus clock not counting");

endmodule

// *** verif/pin_irq_monitor.sv ***
`timescale 1ns/1ns
module pin_irq_monitor (
  // observed pin
  input wire logic ref_clk,
  input wire logic pinOut,
  input wire logic pinOe,
  // measured waveform
  output int riseCount,
  output int riseGap,
  output int highLen
);
  int sinceRise;
  logic pinLast;
  initial begin
    riseCount = 0;
    riseGap = 0;
    highLen = 0;
    sinceRise = 0;
    pinLast = 1'b0;
  end
  // an undriven pin reads low, as with a pull-down on the board
  always @(posedge ref_clk) begin
    pinLast <= pinOut & pinOe;
    sinceRise <= sinceRise + 1;
    if ((pinOut & pinOe) && !pinLast) begin
      riseCount <= riseCount + 1;
      riseGap <= sinceRise + 1;
      sinceRise <= 0;
      highLen <= 1;
    end else if (pinOut & pinOe) begin
      highLen <= highLen + 1;
    end
  end
endmodule

// *** verif/tb_autonomous_periodic_interrupt.sv ***
`timescale 1ns/1ns
`include "periodic_wakeup_params.svh"
module tb_autonomous_periodic_interrupt;
  logic ref_clk, srst, read, write, rcTick, regEn;
  logic waitrequest, periodicIrq, extPinOut, extPinOe, irq;
  logic [15:0] address;
  logic [31:0] writedata, readdata, q;
  logic [1:0] response;
  int err_total, samples_checked, cycles, riseCount, riseGap, highLen;
  autonomous_periodic_interrupt i_autonomous_periodic_interrupt (
    .ref_clk(ref_clk), .srst(srst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(4'hf),
    .readdata(readdata), .waitrequest(waitrequest), .response(response),
    .rcTick(rcTick), .regulator_enable_input(regEn),
    .periodicIrq(periodicIrq), .extPinOut(extPinOut),
    .extPinOe(extPinOe), .irq(irq));
  pin_irq_monitor i_pin_irq_monitor (.ref_clk(ref_clk),
    .pinOut(extPinOut), .pinOe(extPinOe), .riseCount(riseCount),
    .riseGap(riseGap), .highLen(highLen));
  task check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // request held until the rising edge at which waitrequest is seen low
  task bus(input logic wr, input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    address <= a;
    write <= wr;
    read <= !wr;
    writedata <= {4{d}};
    do @(posedge ref_clk); while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    // one more edge so the effect of the access has settled
    @(posedge ref_clk);
  endtask
  task rd(input logic [15:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    check(q[7:0], exp);
  endtask
  task wait_rises(input int n);
    int s;
    s = riseCount;
    repeat (300) if (riseCount < s + n) @(posedge ref_clk);
    repeat (3) @(posedge ref_clk);
  endtask
  task toggles(input int n);
    repeat (n) begin
      repeat (2) @(posedge ref_clk);
      rcTick <= ~rcTick;
    end
  endtask
  task t_reset;
    rd(`CTRL_OFFSET, 8'h00);
    rd(16'h0400, 8'h00);
    rd(`PERIOD_OFFSET, 8'h09);
    check({6'h0, response}, 8'h00);
  endtask
  task t_clksel_lock;
    bus(1'b1, `CTRL_OFFSET, 8'h84);
    rd(`CTRL_OFFSET, 8'h04);
    bus(1'b1, `CTRL_OFFSET, 8'h00);
    bus(1'b1, `CTRL_OFFSET, 8'h80);
    rd(`CTRL_OFFSET, 8'h80);
  endtask
  task t_pulses;
    int s;
    bus(1'b1, `IRQ_MASK_OFFSET, 8'h01);
    bus(1'b1, `CTRL_OFFSET, 8'h8e);
    wait_rises(2);
    check(riseGap[7:0], 8'h0a);
    check(highLen[7:0], 8'h01);
    check({7'h0, periodicIrq}, 8'h01);
    check({7'h0, irq}, 8'h01);
    bus(1'b1, `CTRL_OFFSET, 8'h8c);
    check({7'h0, periodicIrq}, 8'h00);
    bus(1'b1, `CTRL_OFFSET, 8'h88);
    rd(`CTRL_OFFSET, 8'h89);
    check({7'h0, extPinOe}, 8'h00);
    bus(1'b1, `CTRL_OFFSET, 8'h89);
    rd(`CTRL_OFFSET, 8'h88);
    // disabled: no pin activity and no new timeout may appear
    s = riseCount;
    repeat (40) @(posedge ref_clk);
    check(riseCount[7:0], s[7:0]);
    rd(`CTRL_OFFSET, 8'h88);
    bus(1'b1, `IRQ_STATUS_OFFSET, 8'h01);
    check({7'h0, irq}, 8'h00);
  endtask
  task t_clock_wave;
    bus(1'b1, `CTRL_OFFSET, 8'h9c);
    wait_rises(2);
    check(riseGap[7:0], 8'h14);
    bus(1'b1, `CTRL_OFFSET, 8'h94);
    // the pin enable is registered one edge behind the control byte
    @(posedge ref_clk);
    check({7'h0, extPinOe}, 8'h00);
    bus(1'b1, `CTRL_OFFSET, 8'h81);
  endtask
  task t_shutdown;
    bus(1'b1, `CTRL_OFFSET, 8'h01);
    bus(1'b1, `CTRL_OFFSET, 8'h04);
    regEn <= 1'b0;
    toggles(40);
    rd(`CTRL_OFFSET, 8'h04);
    regEn <= 1'b1;
    toggles(40);
    rd(`CTRL_OFFSET, 8'h05);
  endtask
  task tally_and_finish;
    $display("errors %0d checks %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // the whole run needs a few hundred cycles
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total++;
      tally_and_finish();
    end
  end
  initial begin
    {read, write, rcTick, address, writedata} = '0;
    regEn = 1'b1;
    srst = 1'b1;
    cycles = 0;
    err_total = 0;
    samples_checked = 0;
    repeat (16) @(posedge ref_clk);
    srst <= 1'b0;
    t_reset();
    t_clksel_lock();
    t_pulses();
    t_clock_wave();
    t_shutdown();
    tally_and_finish();
  end
endmodule
